// [p4c_board.sv]
`timescale 1ns/1ns
`default_nettype none
module p4c_board (
  input wire logic pad_o_i,
  input wire logic pad_oe_i,
  input wire logic pulldown_en_i,
  input wire logic ext_en_i,
  input wire logic ext_level_i,
  output logic pad_level_o
);
  // device driver first, then an external driver, then the pad pulldown, else the board pull-up
  always_comb begin
    if (pad_oe_i) begin
      pad_level_o = pad_o_i;
    end else if (ext_en_i) begin
      pad_level_o = ext_level_i;
    end else begin
      pad_level_o = !pulldown_en_i;
    end
  end
endmodule : p4c_board
`default_nettype wire

// [p4c_debounce.sv]
`timescale 1ns/1ns
`default_nettype none
module p4c_debounce (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic long_sel_i,
  input wire logic level_i,
  output logic level_o
);
  logic [p4c_pkg::DEB_CNT_W-1:0] cnt_q;
  logic [p4c_pkg::DEB_CNT_W-1:0] limit_m1;
  logic level_q;

  assign limit_m1 = long_sel_i ? p4c_pkg::DEB_CNT_W'(p4c_pkg::DEB_LONG_CYC - 1)
                               : p4c_pkg::DEB_CNT_W'(p4c_pkg::DEB_SHORT_CYC - 1);
  assign level_o = level_q;

  // ----------------------------------------
  // filter: level must differ for the whole window
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (en_i) begin
      if (level_i == level_q) begin
        cnt_q <= '0;
      end else if (cnt_q >= limit_m1) begin
        cnt_q <= '0;
        level_q <= level_i;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_deb_accept;
    @(posedge clk_i) disable iff (!rst_n_i)
    (en_i && level_i != level_q && cnt_q >= limit_m1) |=> (level_q == $past(level_i));
  endproperty
  a_deb_accept: assert property (p_deb_accept) else $error("debounce did not accept stable level");

  property p_deb_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (level_q != $past(level_q)) |-> ($past(cnt_q) >= $past(limit_m1));
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("debounced level changed early");

  c_deb_change: cover property (@(posedge clk_i) disable iff (!rst_n_i) level_q != $past(level_q));
endmodule : p4c_debounce
`default_nettype wire

// [p4c_pkg.sv]
`default_nettype none
package p4c_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] PIN4_CONTROL_ADDR = 8'h44;
  localparam logic [7:0] PIN4_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam int BIT_OUT_VALUE = 0;
  localparam int BIT_PAD_LEVEL = 1;
  localparam int BIT_DIRECTION_SEL = 2;
  localparam int BIT_PULLDOWN_EN = 3;
  localparam int BIT_DEBOUNCE_SEL = 4;
  localparam int BIT_OPEN_DRAIN_EN = 5;
  localparam int BIT_OUT_SOURCE_SEL = 6;
  localparam int BIT_SLEEP_FORCE_LOW = 7;
  localparam logic [7:0] WRITE_MASK = 8'hFD;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEB_SHORT_NS = 94000;
  localparam int DEB_LONG_NS = 156000;
  localparam int DEB_SHORT_CYC = (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_LONG_CYC = (DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CNT_W = 11;
  localparam int SYNC_W = 2;

  // ----------------------------------------
  // control sequence
  // ----------------------------------------
  typedef enum logic [1:0] {
    P4C_ST_LOAD = 2'b01,
    P4C_ST_RUN = 2'b10
  } p4c_state_t;
endpackage : p4c_pkg
`default_nettype wire

// [p4c_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module p4c_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sleep = 1'b0, led = 1'b0, clk_en = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, otp = 8'h0A, rdata;
  logic pad, pad_o, pad_oe, pd_en, seq, deb, ext_en = 1'b0, ext_lvl = 1'b0;
  int mismatches = 0, check_count = 0, cycles = 0;
  p4c_top p4c_top_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(clk_en), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OTP_DEFAULT_I(otp), .SLEEP_I(sleep), .LED_B_DRIVER_I(led),
    .PAD_I(pad), .PAD_O(pad_o), .PAD_OE_O(pad_oe), .PULLDOWN_EN_O(pd_en), .SEQ_ASSIGN_O(seq),
    .DEBOUNCED_O(deb));
  p4c_board p4c_board_inst (.pad_o_i(pad_o), .pad_oe_i(pad_oe), .pulldown_en_i(pd_en), .ext_en_i(ext_en),
    .ext_level_i(ext_lvl), .pad_level_o(pad));
  initial begin
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_load();
    logic [7:0] d;
    rd_reg(8'h44, d);
    chk(d, 8'h08, "otp load");
    cyc(1);
    chk(rdata, 8'h00, "read data gone");
    chk({7'h00, pd_en}, 8'h01, "pulldown on");
    rd_reg(8'h45, d);
    chk(d, 8'h00, "unmapped read");
  endtask : t_reset_load
  task automatic t_push_pull();
    logic [7:0] d;
    wr_reg(8'h44, 8'h06);
    cyc(4);
    chk({5'h00, seq, pad_oe, pad_o}, 8'h06, "out low");
    rd_reg(8'h44, d);
    chk(d, 8'h04, "status low ignores write");
    wr_reg(8'h44, 8'h05);
    cyc(4);
    chk({6'h00, pad_oe, pad_o}, 8'h03, "out high");
    rd_reg(8'h44, d);
    chk(d, 8'h07, "status high");
  endtask : t_push_pull
  task automatic t_source_drain();
    wr_reg(8'h44, 8'h44);
    led <= 1'b1;
    cyc(2);
    chk({7'h00, pad_o}, 8'h01, "led high");
    led <= 1'b0;
    cyc(2);
    chk({7'h00, pad_o}, 8'h00, "led low");
    wr_reg(8'h44, 8'h24);
    cyc(2);
    chk({6'h00, pad_oe, pad_o}, 8'h02, "drain low");
    wr_reg(8'h44, 8'h25);
    cyc(2);
    chk({7'h00, pad_oe}, 8'h00, "drain released");
  endtask : t_source_drain
  task automatic t_sleep();
    wr_reg(8'h44, 8'h85);
    sleep <= 1'b1;
    cyc(5);
    chk({6'h00, pad_oe, pad_o}, 8'h02, "sleep forced low");
    wr_reg(8'h44, 8'h05);
    cyc(2);
    chk({6'h00, pad_oe, pad_o}, 8'h03, "sleep no force");
    sleep <= 1'b0;
  endtask : t_sleep
  task automatic t_input_debounce();
    int n;
    wr_reg(8'h44, 8'h00);
    ext_en <= 1'b1;
    cyc(2);
    chk({6'h00, pd_en, pad_oe}, 8'h00, "input mode");
    for (int s = 0; s < 2; s++) begin
      n = (s == 0) ? p4c_pkg::DEB_SHORT_CYC : p4c_pkg::DEB_LONG_CYC;
      wr_reg(8'h44, (s == 0) ? 8'h00 : 8'h10);
      ext_lvl <= ~ext_lvl;
      cyc(n - 30);
      chk({7'h00, deb}, {7'h00, ~ext_lvl}, "debounce early");
      cyc(60);
      chk({7'h00, deb}, {7'h00, ext_lvl}, "debounce done");
    end
  endtask : t_input_debounce
  task automatic t_clock_hold();
    logic [7:0] d;
    wr_reg(8'h44, 8'h05);
    cyc(2);
    clk_en <= 1'b0;
    wr_reg(8'h44, 8'h00);
    cyc(2);
    chk({6'h00, pad_oe, pad_o}, 8'h03, "frozen drive");
    clk_en <= 1'b1;
    rd_reg(8'h44, d);
    chk(d, 8'h07, "frozen write ignored");
  endtask : t_clock_hold
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_reset_load();
    t_push_pull();
    t_source_drain();
    t_sleep();
    t_input_debounce();
    t_clock_hold();
    test_done();
  end
endmodule : p4c_tb_top
`default_nettype wire

// [p4c_top.sv]
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module p4c_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic [7:0] OTP_DEFAULT_I,
  input wire logic SLEEP_I,
  input wire logic LED_B_DRIVER_I,
  input wire logic PAD_I,
  output logic PAD_O,
  output logic PAD_OE_O,
  output logic PULLDOWN_EN_O,
  output logic SEQ_ASSIGN_O,
  output logic DEBOUNCED_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == p4c_pkg::PIN4_CONTROL_ADDR);
  endfunction : reg_hit

  p4c_pkg::p4c_state_t state_q;
  logic [7:0] ctrl_q;
  logic [7:0] rdata_q;
  logic [p4c_pkg::SYNC_W-1:0] sync_in;
  logic [p4c_pkg::SYNC_W-1:0] sync1_q;
  logic [p4c_pkg::SYNC_W-1:0] sync2_q;
  logic pad_s;
  logic sleep_s;
  logic out_mode;
  logic od_mode;
  logic force_low;
  logic drive_level;
  logic pad_o_d;
  logic pad_oe_d;
  logic pad_o_q;
  logic pad_oe_q;
  logic wr_hit;
  logic rd_hit;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  assign sync_in = {SLEEP_I, PAD_I};

  generate
    for (genvar i = 0; i < p4c_pkg::SYNC_W; i++) begin : g_sync
      always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else if (CLK_EN_I) begin
          sync1_q[i] <= sync_in[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  assign pad_s = sync2_q[0];
  assign sleep_s = sync2_q[1];

  // ----------------------------------------
  // default load, then run
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= p4c_pkg::P4C_ST_LOAD;
    end else if (CLK_EN_I) begin
      case (state_q)
        p4c_pkg::P4C_ST_LOAD: begin
          state_q <= p4c_pkg::P4C_ST_RUN;
        end
        p4c_pkg::P4C_ST_RUN: begin
          state_q <= p4c_pkg::P4C_ST_RUN;
        end
        default: begin
          state_q <= p4c_pkg::P4C_ST_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  assign wr_hit = WR_I && reg_hit(ADDR_I);
  assign rd_hit = RD_I && reg_hit(ADDR_I);

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= p4c_pkg::PIN4_CONTROL_RESET;
    end else if (CLK_EN_I) begin
      if (state_q == p4c_pkg::P4C_ST_LOAD) begin
        ctrl_q <= OTP_DEFAULT_I & p4c_pkg::WRITE_MASK;
      end else if (wr_hit) begin
        ctrl_q <= WDATA_I & p4c_pkg::WRITE_MASK;
      end
    end
  end

  // read data stand for one cycle only; other addresses read zero
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= p4c_pkg::RDATA_IDLE;
    end else if (CLK_EN_I) begin
      if (rd_hit) begin
        rdata_q <= ctrl_q;
        rdata_q[p4c_pkg::BIT_PAD_LEVEL] <= pad_s;
      end else begin
        rdata_q <= p4c_pkg::RDATA_IDLE;
      end
    end
  end

  assign RDATA_O = rdata_q;

  // ----------------------------------------
  // pad drive
  // ----------------------------------------
  assign out_mode = ctrl_q[p4c_pkg::BIT_DIRECTION_SEL];
  assign od_mode = ctrl_q[p4c_pkg::BIT_OPEN_DRAIN_EN];
  assign force_low = sleep_s && ctrl_q[p4c_pkg::BIT_SLEEP_FORCE_LOW];

  always_comb begin
    if (force_low) begin
      drive_level = 1'b0;
    end else if (ctrl_q[p4c_pkg::BIT_OUT_SOURCE_SEL]) begin
      drive_level = LED_B_DRIVER_I;
    end else begin
      drive_level = ctrl_q[p4c_pkg::BIT_OUT_VALUE];
    end
    if (!out_mode) begin
      pad_o_d = 1'b0;
      pad_oe_d = 1'b0;
    end else if (od_mode) begin
      pad_o_d = 1'b0;
      pad_oe_d = !drive_level;
    end else begin
      pad_o_d = drive_level;
      pad_oe_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pad_o_q <= 1'b0;
      pad_oe_q <= 1'b0;
    end else if (CLK_EN_I) begin
      pad_o_q <= pad_o_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  assign PAD_O = pad_o_q;
  assign PAD_OE_O = pad_oe_q;
  assign PULLDOWN_EN_O = ctrl_q[p4c_pkg::BIT_PULLDOWN_EN];
  assign SEQ_ASSIGN_O = ctrl_q[p4c_pkg::BIT_DIRECTION_SEL];

  // ----------------------------------------
  // input filter
  // ----------------------------------------
  p4c_debounce u_debounce (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .en_i(CLK_EN_I),
    .long_sel_i(ctrl_q[p4c_pkg::BIT_DEBOUNCE_SEL]),
    .level_i(pad_s),
    .level_o(DEBOUNCED_O)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_sleep_low;
    (CLK_EN_I && sleep_s && out_mode && ctrl_q[p4c_pkg::BIT_SLEEP_FORCE_LOW]) |=> (PAD_OE_O && !PAD_O);
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("sleep did not force pin low");

  property p_led_source;
    (CLK_EN_I && out_mode && !od_mode && !force_low && ctrl_q[p4c_pkg::BIT_OUT_SOURCE_SEL])
      |=> (PAD_O == $past(LED_B_DRIVER_I));
  endproperty
  a_led_source: assert property (p_led_source) else $error("led source not on pin");

  property p_value_source;
    (CLK_EN_I && out_mode && !od_mode && !force_low && !ctrl_q[p4c_pkg::BIT_OUT_SOURCE_SEL])
      |=> (PAD_O == $past(ctrl_q[p4c_pkg::BIT_OUT_VALUE]));
  endproperty
  a_value_source: assert property (p_value_source) else $error("out value not on pin");

  property p_pulldown_write;
    (CLK_EN_I && state_q == p4c_pkg::P4C_ST_RUN && wr_hit)
      |=> (PULLDOWN_EN_O == $past(WDATA_I[p4c_pkg::BIT_PULLDOWN_EN]));
  endproperty
  a_pulldown_write: assert property (p_pulldown_write) else $error("pulldown does not follow write");

  property p_input_mode;
    (CLK_EN_I && !out_mode) |=> !PAD_OE_O;
  endproperty
  a_input_mode: assert property (p_input_mode) else $error("driver on in input mode");

  property p_open_drain;
    (CLK_EN_I && out_mode && od_mode) |=> (!PAD_O && (PAD_OE_O == !$past(drive_level)));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_level_read;
    (CLK_EN_I && rd_hit) |=> (RDATA_O[p4c_pkg::BIT_PAD_LEVEL] == $past(pad_s));
  endproperty
  a_level_read: assert property (p_level_read) else $error("pad level read wrong");

  property p_level_nowrite;
    (CLK_EN_I && wr_hit) |=> !ctrl_q[p4c_pkg::BIT_PAD_LEVEL];
  endproperty
  a_level_nowrite: assert property (p_level_nowrite) else $error("pad level bit stored");

  property p_otp_load;
    (CLK_EN_I && state_q == p4c_pkg::P4C_ST_LOAD)
      |=> (ctrl_q == ($past(OTP_DEFAULT_I) & p4c_pkg::WRITE_MASK)) ##1 (state_q == p4c_pkg::P4C_ST_RUN);
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("defaults not loaded");

  // ----------------------------------------
  // bus and freeze checks
  // ----------------------------------------
  // a low clock enable must leave every register as it was
  property p_freeze_ctrl;
    !CLK_EN_I |=> $stable(ctrl_q);
  endproperty
  a_freeze_ctrl: assert property (p_freeze_ctrl) else $error("control changed while frozen");

  property p_freeze_pad;
    !CLK_EN_I |=> ($stable(PAD_O) && $stable(PAD_OE_O));
  endproperty
  a_freeze_pad: assert property (p_freeze_pad) else $error("pad drive changed while frozen");

  property p_freeze_rdata;
    !CLK_EN_I |=> $stable(RDATA_O);
  endproperty
  a_freeze_rdata: assert property (p_freeze_rdata) else $error("read data changed while frozen");

  property p_rdata_idle;
    (CLK_EN_I && !rd_hit) |=> (RDATA_O == p4c_pkg::RDATA_IDLE);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

  property p_read_value;
    (CLK_EN_I && rd_hit) |=> ((RDATA_O & p4c_pkg::WRITE_MASK) == ($past(ctrl_q) & p4c_pkg::WRITE_MASK));
  endproperty
  a_read_value: assert property (p_read_value) else $error("register read wrong");

  property p_seq_write;
    (CLK_EN_I && state_q == p4c_pkg::P4C_ST_RUN && wr_hit)
      |=> (SEQ_ASSIGN_O == $past(WDATA_I[p4c_pkg::BIT_DIRECTION_SEL]));
  endproperty
  a_seq_write: assert property (p_seq_write) else $error("sequencer hand-over wrong");

  property p_unmapped_write;
    (CLK_EN_I && state_q == p4c_pkg::P4C_ST_RUN && WR_I && !reg_hit(ADDR_I)) |=> $stable(ctrl_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed control");

  property p_push_pull_on;
    (CLK_EN_I && out_mode && !od_mode) |=> PAD_OE_O;
  endproperty
  a_push_pull_on: assert property (p_push_pull_on) else $error("push-pull driver off");

  property p_input_low;
    (CLK_EN_I && !out_mode) |=> !PAD_O;
  endproperty
  a_input_low: assert property (p_input_low) else $error("pad value driven in input mode");

  property p_state_onehot;
    $onehot(state_q);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("sequence state not one-hot");

  c_sleep_low: cover property (CLK_EN_I && force_low && out_mode);
  c_led_out: cover property (CLK_EN_I && out_mode && ctrl_q[p4c_pkg::BIT_OUT_SOURCE_SEL] && LED_B_DRIVER_I);
  c_read: cover property (CLK_EN_I && rd_hit ##1 RDATA_O[p4c_pkg::BIT_PAD_LEVEL]);
  c_od_release: cover property (CLK_EN_I && out_mode && od_mode ##1 !PAD_OE_O);
endmodule : p4c_top
`default_nettype wire
